//--- design/jtag_cfg_pkg.sv
// Shared types and constants for the test access configuration port
package jtag_cfg_pkg;

    typedef enum logic [3:0] {
        TEST_LOGIC_RESET,
        RUN_TEST_IDLE,
        SELECT_DR,
        CAPTURE_DR,
        SHIFT_DR,
        EXIT1_DR,
        PAUSE_DR,
        EXIT2_DR,
        UPDATE_DR,
        SELECT_IR,
        CAPTURE_IR,
        SHIFT_IR,
        EXIT1_IR,
        PAUSE_IR,
        EXIT2_IR,
        UPDATE_IR
    } tap_state_t;

    localparam int         IR_LEN         = 4;
    localparam logic [3:0] INSTR_BYPASS   = 4'hF;
    localparam logic [3:0] INSTR_PROGRAM  = 4'h2;
    localparam logic [3:0] INSTR_STARTUP  = 4'h3;
    localparam logic [3:0] IR_CAPTURE_VAL = 4'h1;

    localparam logic [2:0] TMS_RESET_RUN  = 3'h5;
    localparam logic [2:0] BYTE_LAST_BIT  = 3'h7;
    localparam logic [4:0] INIT_TCK_CYCLES = 5'h10;

    localparam logic [1:0] SCHEME_PASSIVE  = 2'h0;
    localparam logic [1:0] SCHEME_ACTIVE   = 2'h1;
    localparam logic [1:0] SCHEME_PARALLEL = 2'h2;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } jtag_pins_t;

    typedef struct packed {
        logic       data;
        logic       oe;
    } tdo_pin_t;

    typedef struct packed {
        logic [7:0] data;
        logic       valid;
    } cfg_byte_t;

endpackage

//--- design/jtag_config_port.sv
// Test access port with configuration loading and scheme arbitration
module jtag_config_port (
    input  wire logic                    clk,
    input  wire logic                    reset,
    input  wire jtag_cfg_pkg::jtag_pins_t jtagPins,
    output jtag_cfg_pkg::tdo_pin_t       tdoPin,
    input  wire logic [1:0]              schemeSelect,
    input  wire logic                    reconfigureRequestLow,
    input  wire logic                    chainEnableLow,
    input  wire logic                    serialLoadActive,
    input  wire logic                    activeSerialClk,
    input  wire jtag_cfg_pkg::cfg_byte_t parallelByte,
    input  wire logic                    imageDone,
    input  wire logic                    imageError,
    output jtag_cfg_pkg::cfg_byte_t      cfgOut,
    output logic                         abortOut,
    output logic                         testPortLoading,
    output logic                         decompressBypass,
    output logic                         configClock,
    output logic                         configClockOe,
    output logic                         loadComplete,
    output logic                         chainEnableOutLow
);

    // Pin synchronisers: tck, tms, tdi, reconfigure, chain enable
    logic [4:0] pinMeta_q;
    logic [4:0] pinMeta_d;
    logic [4:0] pinSync_q;
    logic [4:0] pinSync_d;
    logic       tckLast_q;
    logic       tckLast_d;

    logic       tckSync;
    logic       tmsSync;
    logic       tdiSync;
    logic       reconfigSyncLow;
    logic       chainSyncLow;
    logic       tckRise;
    logic       tckFall;

    always_comb begin
        pinMeta_d = {jtagPins.tck, jtagPins.tms, jtagPins.tdi,
                     reconfigureRequestLow, chainEnableLow};
        pinSync_d = pinMeta_q;
        tckLast_d = pinSync_q[4];
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            // Idle levels: TCK low, TMS and TDI high, requests inactive
            pinMeta_q <= 5'h0F;
            pinSync_q <= 5'h0F;
            tckLast_q <= 1'b0;
        end else begin
            pinMeta_q <= pinMeta_d;
            pinSync_q <= pinSync_d;
            tckLast_q <= tckLast_d;
        end
    end

    assign tckSync         = pinSync_q[4];
    assign tmsSync         = pinSync_q[3];
    assign tdiSync         = pinSync_q[2];
    assign reconfigSyncLow = pinSync_q[1];
    assign chainSyncLow    = pinSync_q[0];
    // A parked TCK gives no edges, so the TAP and scan registers below do not advance
    assign tckRise         = tckSync & ~tckLast_q;
    assign tckFall         = ~tckSync & tckLast_q;

    jtag_cfg_pkg::tap_state_t tapState;

    tap_controller u_tap (
        .clk   (clk),
        .reset (reset),
        .step  (tckRise),
        .tms   (tmsSync),
        .state (tapState)
    );

    function automatic logic is_shift(input jtag_cfg_pkg::tap_state_t s);
        is_shift = (s == jtag_cfg_pkg::SHIFT_DR) ||
                   (s == jtag_cfg_pkg::SHIFT_IR);
    endfunction

    // Scan registers and loading control, stepped on TCK rising edges except the reconfigure clear
    logic [3:0] irShift_q;
    logic [3:0] irShift_d;
    logic [3:0] instr_q;
    logic [3:0] instr_d;
    logic       bypass_q;
    logic       bypass_d;
    logic [7:0] dataShift_q;
    logic [7:0] dataShift_d;
    logic [2:0] bitCount_q;
    logic [2:0] bitCount_d;
    logic [4:0] initCount_q;
    logic [4:0] initCount_d;
    logic       loading_q;
    logic       loading_d;
    logic       done_q;
    logic       done_d;
    logic       abort_q;
    logic       abort_d;
    logic       chainOut_q;
    logic       chainOut_d;
    logic       tapByteValid;
    logic [7:0] tapByte;

    always_comb begin
        irShift_d    = irShift_q;
        instr_d      = instr_q;
        bypass_d     = bypass_q;
        dataShift_d  = dataShift_q;
        bitCount_d   = bitCount_q;
        initCount_d  = initCount_q;
        loading_d    = loading_q;
        done_d       = done_q;
        abort_d      = 1'b0;
        tapByteValid = 1'b0;
        tapByte      = {tdiSync, dataShift_q[7:1]};
        if (tckRise) begin
            unique case (tapState)
                jtag_cfg_pkg::TEST_LOGIC_RESET: begin
                    instr_d = jtag_cfg_pkg::INSTR_BYPASS;
                end
                jtag_cfg_pkg::CAPTURE_IR: begin
                    irShift_d = jtag_cfg_pkg::IR_CAPTURE_VAL;
                end
                jtag_cfg_pkg::SHIFT_IR: begin
                    irShift_d = {tdiSync, irShift_q[3:1]};
                end
                jtag_cfg_pkg::UPDATE_IR: begin
                    instr_d     = irShift_q;
                    initCount_d = 5'h00;
                    if (irShift_q == jtag_cfg_pkg::INSTR_PROGRAM) begin
                        loading_d = 1'b1;
                        done_d    = 1'b0;
                        abort_d   = serialLoadActive;
                    end
                end
                jtag_cfg_pkg::CAPTURE_DR: begin
                    bypass_d   = 1'b0;
                    bitCount_d = 3'h0;
                end
                jtag_cfg_pkg::SHIFT_DR: begin
                    if (instr_q == jtag_cfg_pkg::INSTR_PROGRAM) begin
                        dataShift_d = tapByte;
                        bitCount_d  = bitCount_q + 3'h1;
                        if (bitCount_q == jtag_cfg_pkg::BYTE_LAST_BIT) begin
                            tapByteValid = loading_q;
                        end
                    end else begin
                        bypass_d = tdiSync;
                    end
                end
                jtag_cfg_pkg::RUN_TEST_IDLE: begin
                    // Initialization consumes the host's trailing clocks
                    if (instr_q == jtag_cfg_pkg::INSTR_STARTUP &&
                            loading_q) begin
                        if (initCount_q != jtag_cfg_pkg::INIT_TCK_CYCLES) begin
                            initCount_d = initCount_q + 5'h01;
                        end else if (imageDone || imageError) begin
                            loading_d = 1'b0;
                            done_d    = imageDone && !imageError;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
        // A reconfigure request drops any load and its completion flag
        if (!reconfigSyncLow) begin
            loading_d = 1'b0;
            done_d    = 1'b0;
        end
        chainOut_d = !done_d;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            irShift_q   <= 4'h0;
            instr_q     <= jtag_cfg_pkg::INSTR_BYPASS;
            bypass_q    <= 1'b0;
            dataShift_q <= 8'h00;
            bitCount_q  <= 3'h0;
            initCount_q <= 5'h00;
            loading_q   <= 1'b0;
            done_q      <= 1'b0;
            abort_q     <= 1'b0;
            chainOut_q  <= 1'b1;
        end else begin
            irShift_q   <= irShift_d;
            instr_q     <= instr_d;
            bypass_q    <= bypass_d;
            dataShift_q <= dataShift_d;
            bitCount_q  <= bitCount_d;
            initCount_q <= initCount_d;
            loading_q   <= loading_d;
            done_q      <= done_d;
            abort_q     <= abort_d;
            chainOut_q  <= chainOut_d;
        end
    end

    // Registered outputs: data stream, scheme steering and TDO
    jtag_cfg_pkg::cfg_byte_t cfgOut_q;
    jtag_cfg_pkg::cfg_byte_t cfgOut_d;
    jtag_cfg_pkg::tdo_pin_t  tdo_q;
    jtag_cfg_pkg::tdo_pin_t  tdo_d;
    logic                    cfgClk_q;
    logic                    cfgClk_d;
    logic                    cfgClkOe_q;
    logic                    cfgClkOe_d;

    always_comb begin
        cfgOut_d = '0;
        tdo_d    = tdo_q;
        if (tapByteValid) begin
            cfgOut_d.data  = tapByte;
            cfgOut_d.valid = 1'b1;
        end else if (!loading_q && !chainSyncLow && parallelByte.valid) begin
            // Parallel bytes only while no test-port load owns the stream
            cfgOut_d = parallelByte;
        end
        // An active serial clock would fight a test-port load, so its output enable is dropped
        cfgClk_d   = activeSerialClk;
        cfgClkOe_d = (schemeSelect == jtag_cfg_pkg::SCHEME_ACTIVE) &&
                     !loading_q;
        if (tckFall) begin
            tdo_d.oe = is_shift(tapState);
            if (tapState == jtag_cfg_pkg::SHIFT_IR) begin
                tdo_d.data = irShift_q[0];
            end else if (instr_q == jtag_cfg_pkg::INSTR_PROGRAM) begin
                tdo_d.data = dataShift_q[0];
            end else begin
                tdo_d.data = bypass_q;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            cfgOut_q   <= '0;
            tdo_q      <= '0;
            cfgClk_q   <= 1'b0;
            cfgClkOe_q <= 1'b0;
        end else begin
            cfgOut_q   <= cfgOut_d;
            tdo_q      <= tdo_d;
            cfgClk_q   <= cfgClk_d;
            cfgClkOe_q <= cfgClkOe_d;
        end
    end

    assign cfgOut            = cfgOut_q;
    assign tdoPin            = tdo_q;
    assign configClock       = cfgClk_q;
    assign configClockOe     = cfgClkOe_q;
    assign abortOut          = abort_q;
    assign testPortLoading   = loading_q;
    assign decompressBypass  = loading_q;
    assign loadComplete      = done_q;
    assign chainEnableOutLow = chainOut_q;

    property p_tdo_on_fall;
        @(posedge clk) disable iff (reset)
        $changed(tdo_q) |-> $past(tckFall);
    endproperty
    a_tdo_on_fall: assert property (p_tdo_on_fall)
        else $error("TDO changed outside a TCK falling edge");

    property p_tdo_released;
        @(posedge clk) disable iff (reset)
        (tckFall && !is_shift(tapState)) |=> !tdo_q.oe;
    endproperty
    a_tdo_released: assert property (p_tdo_released)
        else $error("TDO driven outside a shift state");

    property p_bypass_bit;
        @(posedge clk) disable iff (reset)
        (tckRise && tapState == jtag_cfg_pkg::SHIFT_DR &&
         instr_q == jtag_cfg_pkg::INSTR_BYPASS) |=> (bypass_q == $past(tdiSync));
    endproperty
    a_bypass_bit: assert property (p_bypass_bit)
        else $error("Bypass register did not take TDI");
    property p_serial_abort;
        @(posedge clk) disable iff (reset)
        (tckRise && tapState == jtag_cfg_pkg::UPDATE_IR && serialLoadActive &&
         irShift_q == jtag_cfg_pkg::INSTR_PROGRAM) |=> (abortOut && loading_q);
    endproperty
    a_serial_abort: assert property (p_serial_abort)
        else $error("Passive serial load not aborted");
    property p_as_clock_off;
        @(posedge clk) disable iff (reset)
        loading_q |=> !configClockOe;
    endproperty
    a_as_clock_off: assert property (p_as_clock_off)
        else $error("Config clock driven during test-port load");

    property p_priority;
        @(posedge clk) disable iff (reset)
        (loading_q && !tapByteValid) |=> !cfgOut.valid;
    endproperty
    a_priority: assert property (p_priority)
        else $error("Other scheme data passed during test-port load");
    property p_broadcast;
        @(posedge clk) disable iff (reset)
        (!loading_q && !chainSyncLow && parallelByte.valid) |=>
            (cfgOut.valid && cfgOut.data == $past(parallelByte.data));
    endproperty
    a_broadcast: assert property (p_broadcast)
        else $error("Broadcast parallel byte dropped");
    property p_decomp;
        @(posedge clk) disable iff (reset)
        $rose(loading_q) |-> decompressBypass ##1 (decompressBypass == loading_q);
    endproperty
    a_decomp: assert property (p_decomp)
        else $error("Decompression not bypassed for test-port load");
    property p_done_ok;
        @(posedge clk) disable iff (reset)
        $rose(loadComplete) |-> ($past(imageDone) && !$past(imageError) &&
            $past(initCount_q) == jtag_cfg_pkg::INIT_TCK_CYCLES);
    endproperty
    a_done_ok: assert property (p_done_ok)
        else $error("Load complete raised without a clean image");

endmodule

//--- design/tap_controller.sv
// Sixteen-state test access port controller, stepped by TCK rising edges
module tap_controller (
    input  wire logic                    clk,
    input  wire logic                    reset,
    input  wire logic                    step,
    input  wire logic                    tms,
    output jtag_cfg_pkg::tap_state_t     state
);

    jtag_cfg_pkg::tap_state_t state_q;
    jtag_cfg_pkg::tap_state_t state_d;
    logic [2:0]               tmsRun_q;
    logic [2:0]               tmsRun_d;

    assign state = state_q;

    always_comb begin
        state_d  = state_q;
        tmsRun_d = tmsRun_q;
        if (step) begin
            if (!tms) begin
                tmsRun_d = 3'h0;
            end else if (tmsRun_q != jtag_cfg_pkg::TMS_RESET_RUN) begin
                tmsRun_d = tmsRun_q + 3'h1;
            end
            unique case (state_q)
                jtag_cfg_pkg::TEST_LOGIC_RESET: state_d = tms ?
                    jtag_cfg_pkg::TEST_LOGIC_RESET : jtag_cfg_pkg::RUN_TEST_IDLE;
                jtag_cfg_pkg::RUN_TEST_IDLE: state_d = tms ?
                    jtag_cfg_pkg::SELECT_DR : jtag_cfg_pkg::RUN_TEST_IDLE;
                jtag_cfg_pkg::SELECT_DR: state_d = tms ?
                    jtag_cfg_pkg::SELECT_IR : jtag_cfg_pkg::CAPTURE_DR;
                jtag_cfg_pkg::CAPTURE_DR: state_d = tms ?
                    jtag_cfg_pkg::EXIT1_DR : jtag_cfg_pkg::SHIFT_DR;
                jtag_cfg_pkg::SHIFT_DR: state_d = tms ?
                    jtag_cfg_pkg::EXIT1_DR : jtag_cfg_pkg::SHIFT_DR;
                jtag_cfg_pkg::EXIT1_DR: state_d = tms ?
                    jtag_cfg_pkg::UPDATE_DR : jtag_cfg_pkg::PAUSE_DR;
                jtag_cfg_pkg::PAUSE_DR: state_d = tms ?
                    jtag_cfg_pkg::EXIT2_DR : jtag_cfg_pkg::PAUSE_DR;
                jtag_cfg_pkg::EXIT2_DR: state_d = tms ?
                    jtag_cfg_pkg::UPDATE_DR : jtag_cfg_pkg::SHIFT_DR;
                jtag_cfg_pkg::UPDATE_DR: state_d = tms ?
                    jtag_cfg_pkg::SELECT_DR : jtag_cfg_pkg::RUN_TEST_IDLE;
                jtag_cfg_pkg::SELECT_IR: state_d = tms ?
                    jtag_cfg_pkg::TEST_LOGIC_RESET : jtag_cfg_pkg::CAPTURE_IR;
                jtag_cfg_pkg::CAPTURE_IR: state_d = tms ?
                    jtag_cfg_pkg::EXIT1_IR : jtag_cfg_pkg::SHIFT_IR;
                jtag_cfg_pkg::SHIFT_IR: state_d = tms ?
                    jtag_cfg_pkg::EXIT1_IR : jtag_cfg_pkg::SHIFT_IR;
                jtag_cfg_pkg::EXIT1_IR: state_d = tms ?
                    jtag_cfg_pkg::UPDATE_IR : jtag_cfg_pkg::PAUSE_IR;
                jtag_cfg_pkg::PAUSE_IR: state_d = tms ?
                    jtag_cfg_pkg::EXIT2_IR : jtag_cfg_pkg::PAUSE_IR;
                jtag_cfg_pkg::EXIT2_IR: state_d = tms ?
                    jtag_cfg_pkg::UPDATE_IR : jtag_cfg_pkg::SHIFT_IR;
                jtag_cfg_pkg::UPDATE_IR: state_d = tms ?
                    jtag_cfg_pkg::SELECT_DR : jtag_cfg_pkg::RUN_TEST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_q  <= jtag_cfg_pkg::TEST_LOGIC_RESET;
            tmsRun_q <= 3'h0;
        end else begin
            state_q  <= state_d;
            tmsRun_q <= tmsRun_d;
        end
    end

    property p_tms_reset;
        @(posedge clk) disable iff (reset)
        (tmsRun_q == jtag_cfg_pkg::TMS_RESET_RUN) |->
            (state_q == jtag_cfg_pkg::TEST_LOGIC_RESET);
    endproperty
    a_tms_reset: assert property (p_tms_reset)
        else $error("TMS held high five steps without reaching reset");

    property p_step_only;
        @(posedge clk) disable iff (reset)
        !step |=> $stable(state_q);
    endproperty
    a_step_only: assert property (p_step_only)
        else $error("TAP state moved without a TCK rising edge");

endmodule

//--- verif/jtag_configuration_port_tb.sv
// Self-checking bench for the test access configuration port
module jtag_configuration_port_tb;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic       chainLow;
        logic [7:0] data;
        logic       pass;
    } byte_row_t;

    localparam byte_row_t ROWS [4] = '{'{1'b0, 8'hA5, 1'b1},
        '{1'b1, 8'h3C, 1'b0}, '{1'b0, 8'h00, 1'b1}, '{1'b0, 8'hFF, 1'b1}};

    logic                    clk = 1'b0;
    logic                    reset = 1'b1;
    jtag_cfg_pkg::jtag_pins_t jtagPins;
    jtag_cfg_pkg::tdo_pin_t  tdoPin;
    logic [1:0]              schemeSelect = jtag_cfg_pkg::SCHEME_PARALLEL;
    logic                    reconfigureRequestLow = 1'b1;
    logic                    chainEnableLow = 1'b1;
    logic                    serialLoadActive = 1'b0;
    logic                    activeSerialClk = 1'b0;
    jtag_cfg_pkg::cfg_byte_t parallelByte = '0;
    logic                    imageDone = 1'b0;
    logic                    imageError = 1'b0;
    jtag_cfg_pkg::cfg_byte_t cfgOut;
    logic                    abortOut;
    logic                    testPortLoading;
    logic                    decompressBypass;
    logic                    configClock;
    logic                    configClockOe;
    logic                    loadComplete;
    logic                    chainEnableOutLow;
    int                      num_errors = 0;
    int                      checked = 0;
    int                      abortCount = 0;
    int                      byteCount = 0;
    logic [7:0]              lastByte = 8'h00;

    always #2.5 clk = ~clk;
    always @(posedge clk) activeSerialClk <= ~activeSerialClk;

    always @(posedge clk) begin
        if (abortOut === 1'b1) abortCount++;
        if (cfgOut.valid === 1'b1) begin
            byteCount++;
            lastByte = cfgOut.data;
        end
    end

    jtag_host_model host (.clk(clk), .pins(jtagPins), .tdo(tdoPin));

    jtag_config_port dut (
        .clk                   (clk),
        .reset                 (reset),
        .jtagPins              (jtagPins),
        .tdoPin                (tdoPin),
        .schemeSelect          (schemeSelect),
        .reconfigureRequestLow (reconfigureRequestLow),
        .chainEnableLow        (chainEnableLow),
        .serialLoadActive      (serialLoadActive),
        .activeSerialClk       (activeSerialClk),
        .parallelByte          (parallelByte),
        .imageDone             (imageDone),
        .imageError            (imageError),
        .cfgOut                (cfgOut),
        .abortOut              (abortOut),
        .testPortLoading       (testPortLoading),
        .decompressBypass      (decompressBypass),
        .configClock           (configClock),
        .configClockOe         (configClockOe),
        .loadComplete          (loadComplete),
        .chainEnableOutLow     (chainEnableOutLow)
    );

    task automatic check(input string name, input logic [8:0] exp,
                         input logic [8:0] got);
        checked++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
            num_errors++;
        end
    endtask

    task automatic summarize();
        $display("Counts: %0d checks, %0d mismatches", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic endTest(input string name);
        $display("Test %s done, %0d mismatches so far", name, num_errors);
    endtask

    // Bounded wait for the end of a test-port load
    task automatic waitLoadEnd();
        int i;
        for (i = 0; i < 60 && testPortLoading !== 1'b0; i++)
            @(posedge clk);
        if (testPortLoading !== 1'b0) begin
            $display("CHECK FAILED loadEnd expected 0 seen %b",
                     testPortLoading);
            num_errors++;
            summarize();
        end
        #1;
    endtask

    // One full test-port load: program, one byte, startup, idle clocks
    task automatic loadImage(input logic [7:0] image);
        logic [7:0] dout;
        logic       ok;
        host.shift(1'b1, 4, {4'h0, jtag_cfg_pkg::INSTR_PROGRAM}, dout, ok);
        host.shift(1'b0, 8, image, dout, ok);
        host.shift(1'b1, 4, {4'h0, jtag_cfg_pkg::INSTR_STARTUP}, dout, ok);
        host.runIdle(20);
        waitLoadEnd();
    endtask

    initial begin
        logic [7:0] dout;
        logic       ok;
        int         n;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk) #1;
        check("loadComplete", 9'h0, loadComplete);
        check("chainOut", 9'h1, chainEnableOutLow);
        check("tdoOe", 9'h0, tdoPin.oe);
        endTest("reset");

        foreach (ROWS[r]) begin
            @(posedge clk) chainEnableLow <= ROWS[r].chainLow;
            repeat (4) @(posedge clk);
            parallelByte <= '{data: ROWS[r].data, valid: 1'b1};
            @(posedge clk) parallelByte.valid <= 1'b0;
            #1;
            check("byteValid", ROWS[r].pass, cfgOut.valid);
            if (ROWS[r].pass) check("byteData", ROWS[r].data, cfgOut.data);
        end
        endTest("parallel rows");

        host.tapReset();
        host.shift(1'b0, 8, 8'hB4, dout, ok);
        check("bypassOut", 9'h068, dout);
        check("tdoFallOnly", 9'h1, ok);
        check("tdoOe", 9'h0, tdoPin.oe);
        endTest("bypass");

        @(posedge clk) schemeSelect <= jtag_cfg_pkg::SCHEME_ACTIVE;
        serialLoadActive <= 1'b1;
        repeat (4) @(posedge clk) #1;
        check("clockOe", 9'h1, configClockOe);
        check("configClock", !activeSerialClk, configClock);
        n = abortCount;
        host.shift(1'b1, 4, {4'h0, jtag_cfg_pkg::INSTR_PROGRAM}, dout, ok);
        check("irCapture", jtag_cfg_pkg::IR_CAPTURE_VAL, dout[3:0]);
        repeat (4) @(posedge clk) #1;
        check("loading", 9'h1, testPortLoading);
        check("bypassDecomp", 9'h1, decompressBypass);
        check("clockOe", 9'h0, configClockOe);
        check("serialAbort", 9'h1, abortCount - n);
        @(posedge clk) serialLoadActive <= 1'b0;
        n = byteCount;
        parallelByte <= '{data: 8'h5A, valid: 1'b1};
        @(posedge clk) parallelByte.valid <= 1'b0;
        repeat (3) @(posedge clk) #1;
        check("byteDropped", n, byteCount);
        host.shift(1'b0, 8, 8'hC6, dout, ok);
        repeat (3) @(posedge clk) #1;
        check("tpBytes", n + 1, byteCount);
        check("tpByte", 9'h0C6, lastByte);
        @(posedge clk) imageDone <= 1'b1;
        host.shift(1'b1, 4, {4'h0, jtag_cfg_pkg::INSTR_STARTUP}, dout, ok);
        host.runIdle(20);
        waitLoadEnd();
        check("loadComplete", 9'h1, loadComplete);
        check("chainOut", 9'h0, chainEnableOutLow);
        repeat (3) @(posedge clk) #1;
        check("clockOe", 9'h1, configClockOe);
        endTest("load success");

        @(posedge clk) reconfigureRequestLow <= 1'b0;
        imageDone <= 1'b0;
        imageError <= 1'b1;
        repeat (6) @(posedge clk) #1;
        check("loadComplete", 9'h0, loadComplete);
        @(posedge clk) reconfigureRequestLow <= 1'b1;
        repeat (4) @(posedge clk);
        loadImage(8'h3E);
        check("loadComplete", 9'h0, loadComplete);
        check("chainOut", 9'h1, chainEnableOutLow);
        endTest("load failure");

        host.shift(1'b1, 4, {4'h0, jtag_cfg_pkg::INSTR_PROGRAM}, dout, ok);
        host.tapReset();
        n = byteCount;
        host.shift(1'b0, 8, 8'hB4, dout, ok);
        check("resetBypass", 9'h068, dout);
        check("resetBytes", n, byteCount);
        endTest("tap reset");

        repeat (200) @(posedge clk) #1;
        check("idleBytes", n, byteCount);
        check("idleOe", 9'h0, tdoPin.oe);
        check("idleLoading", 9'h1, testPortLoading);
        endTest("idle pins");
        summarize();
    end
endmodule

//--- verif/jtag_host_model.sv
// Scan host model: drives clock, mode select and data, samples serial out
module jtag_host_model (
    input  wire logic                   clk,
    output jtag_cfg_pkg::jtag_pins_t    pins,
    input  wire jtag_cfg_pkg::tdo_pin_t tdo
);
    timeunit 1ns;
    timeprecision 1ps;

    // Between frames the clock stands low, select and data at pull-up level
    initial pins = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1};

    // A rise every 16 clk gives the 80 ns link clock
    task automatic step(input logic tmsV, input logic tdiV,
                        output jtag_cfg_pkg::tdo_pin_t lo,
                        output jtag_cfg_pkg::tdo_pin_t hi);
        @(posedge clk);
        pins.tms <= tmsV;
        pins.tdi <= tdiV;
        repeat (8) @(posedge clk);
        lo = tdo;
        pins.tck <= 1'b1;
        repeat (7) @(posedge clk);
        hi = tdo;
        pins <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b1};
    endtask

    task automatic tapReset();
        jtag_cfg_pkg::tdo_pin_t lo, hi;
        repeat (5) step(1'b1, 1'b1, lo, hi);
        step(1'b0, 1'b1, lo, hi);
    endtask

    task automatic runIdle(input int n);
        jtag_cfg_pkg::tdo_pin_t lo, hi;
        repeat (n) step(1'b0, 1'b1, lo, hi);
    endtask

    // Output bit k is what stood before shift rise k; ok drops on any
    // change while the clock was high or on a released output
    task automatic shift(input logic isIr, input int n,
                         input logic [7:0] din, output logic [7:0] dout,
                         output logic ok);
        jtag_cfg_pkg::tdo_pin_t lo, hi;
        int k;
        dout = 8'h00;
        ok = 1'b1;
        step(1'b1, 1'b1, lo, hi);
        if (isIr) step(1'b1, 1'b1, lo, hi);
        step(1'b0, 1'b1, lo, hi);
        step(1'b0, 1'b1, lo, hi);
        for (k = 0; k < n; k++) begin
            step(k == n - 1, din[k], lo, hi);
            // A released line floats away from the last driven level
            dout[k] = lo.oe ? lo.data : ~lo.data;
            if (lo.oe !== 1'b1 || hi.oe !== 1'b1 || hi.data !== lo.data)
                ok = 1'b0;
        end
        step(1'b1, 1'b1, lo, hi);
        step(1'b0, 1'b1, lo, hi);
    endtask
endmodule
